// file: rtl/bmg_glue.sv
`timescale 1ns/1ns
`default_nettype none

module bmg_glue (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [bmg_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [15:0] cpu_addr,
    output bmg_pkg::bmg_mem_sel_t mem_sel,
    output logic bank_en,
    output logic [1:0] drive_sel,
    output logic side_sel,
    output logic drive_id,
    input wire logic drive_size_large_sel,
    output logic fdc_clk,
    output logic ext_sep_sel,
    input wire logic [7:0] kbd_data,
    input wire logic kbd_strobe
);

    // ****************************************
    // Register bus
    // ****************************************
    logic access, setup, hit, wr, rd_b;
    bmg_pkg::bmg_porta_t porta_r, porta_nxt;
    logic [7:0] kbd_r, kbd_nxt;
    logic kbd_ready_r, kbd_ready_nxt;
    logic strobe_q_r;
    logic [31:0] prdata_r, prdata_nxt;
    logic take_key;

    assign setup = psel & ~penable;
    assign access = psel & penable;
    assign hit = (paddr == bmg_pkg::PORTA_ADDR) | (paddr == bmg_pkg::PORTB_ADDR) |
                 (paddr == bmg_pkg::STATUS_ADDR);
    // Zero wait states keeps bank switching on the next memory cycle
    assign pready = 1'b1;
    assign pslverr = access & ~hit;
    assign wr = access & pwrite & (paddr == bmg_pkg::PORTA_ADDR);
    assign rd_b = access & ~pwrite & (paddr == bmg_pkg::PORTB_ADDR);
    assign prdata = prdata_r;
    // Strobe taken on its rising edge so a held strobe loads once
    assign take_key = kbd_strobe & ~strobe_q_r;

    always_comb begin
        porta_nxt = porta_r;
        kbd_nxt = kbd_r;
        kbd_ready_nxt = kbd_ready_r;
        prdata_nxt = prdata_r;
        if (wr) begin
            porta_nxt = bmg_pkg::bmg_porta_t'(pwdata[bmg_pkg::PORTA_W-1:0]);
        end
        if (rd_b) begin
            kbd_ready_nxt = 1'b0;
        end
        // Set wins over the read clear
        if (take_key) begin
            kbd_nxt = kbd_data;
            kbd_ready_nxt = 1'b1;
        end
        if (setup) begin
            prdata_nxt = 32'h0;
            unique case (paddr)
                bmg_pkg::PORTA_ADDR: prdata_nxt[bmg_pkg::PORTA_W-1:0] = porta_r;
                bmg_pkg::PORTB_ADDR: prdata_nxt[7:0] = kbd_r;
                bmg_pkg::STATUS_ADDR: begin
                    prdata_nxt[bmg_pkg::ST_KBD_READY] = kbd_ready_r;
                    prdata_nxt[bmg_pkg::ST_SIZE_LARGE] = drive_size_large_sel;
                    prdata_nxt[bmg_pkg::ST_BANK_EN] = porta_r.bank_en;
                end
                default: prdata_nxt = 32'h0;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            porta_r <= bmg_pkg::PORTA_RST;
            kbd_r <= 8'h00;
            kbd_ready_r <= 1'b0;
            strobe_q_r <= 1'b0;
            prdata_r <= 32'h0;
        end else begin
            porta_r <= porta_nxt;
            kbd_r <= kbd_nxt;
            kbd_ready_r <= kbd_ready_nxt;
            strobe_q_r <= kbd_strobe;
            prdata_r <= prdata_nxt;
        end
    end

    assign bank_en = porta_r.bank_en;
    assign drive_sel = porta_r.drive_sel;
    assign side_sel = porta_r.side;
    assign drive_id = porta_r.drive_id;

    // ****************************************
    // Memory decode
    // ****************************************
    // Gaps 1000-2FFF select nothing while the bank is on
    always_comb begin
        mem_sel.rom_sel = bank_en & (cpu_addr[15:12] == bmg_pkg::ROM_PAGE);
        mem_sel.crt_sel = bank_en & (cpu_addr[15:12] == bmg_pkg::CRT_PAGE);
        mem_sel.ram_sel = ~bank_en | (cpu_addr[15:14] != bmg_pkg::LOW16K_TOP);
    end

    // ****************************************
    // Disk clock and separator
    // ****************************************
    logic [bmg_pkg::DIV_W-1:0] div_r, div_nxt, half_last;
    logic fdc_clk_r, fdc_clk_nxt, size_q_r, ext_sep_r;

    assign half_last = drive_size_large_sel ?
                       bmg_pkg::DIV_W'(bmg_pkg::FAST_HALF - 1) :
                       bmg_pkg::DIV_W'(bmg_pkg::SLOW_HALF - 1);

    // Divider restarts on a size change to avoid a runt period
    always_comb begin
        div_nxt = div_r + 1'b1;
        fdc_clk_nxt = fdc_clk_r;
        if (drive_size_large_sel != size_q_r) begin
            div_nxt = '0;
        end else if (div_r >= half_last) begin
            div_nxt = '0;
            fdc_clk_nxt = ~fdc_clk_r;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_r <= '0;
            fdc_clk_r <= 1'b0;
            size_q_r <= 1'b0;
            ext_sep_r <= 1'b0;
        end else begin
            div_r <= div_nxt;
            fdc_clk_r <= fdc_clk_nxt;
            size_q_r <= drive_size_large_sel;
            ext_sep_r <= drive_size_large_sel;
        end
    end

    assign fdc_clk = fdc_clk_r;
    assign ext_sep_sel = ext_sep_r;

    // ****************************************
    // Checks
    // ****************************************
    logic clk_prev_r, tog;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_prev_r <= 1'b0;
        end else begin
            clk_prev_r <= fdc_clk_r;
        end
    end
    assign tog = fdc_clk_r != clk_prev_r;

    property p_bank_reset;
        @(posedge pclk) disable iff (!presetn) $rose(presetn) |-> bank_en;
    endproperty
    a_bank_reset: assert property (p_bank_reset) else $error("bank off after reset");

    property p_rom_map;
        @(posedge pclk) disable iff (!presetn)
        bank_en && cpu_addr < 16'h1000 |-> mem_sel.rom_sel && !mem_sel.ram_sel;
    endproperty
    a_rom_map: assert property (p_rom_map) else $error("rom not decoded");

    property p_crt_map;
        @(posedge pclk) disable iff (!presetn)
        bank_en && cpu_addr >= 16'h3000 && cpu_addr < 16'h4000
        |-> mem_sel.crt_sel && !mem_sel.ram_sel && !mem_sel.rom_sel;
    endproperty
    a_crt_map: assert property (p_crt_map) else $error("display ram not decoded");

    property p_ram_map;
        @(posedge pclk) disable iff (!presetn)
        !bank_en |-> mem_sel.ram_sel && !mem_sel.rom_sel && !mem_sel.crt_sel;
    endproperty
    a_ram_map: assert property (p_ram_map) else $error("program ram not decoded");

    property p_porta_write;
        @(posedge pclk) disable iff (!presetn)
        psel && penable && pwrite && paddr == bmg_pkg::PORTA_ADDR && pready
        |=> bank_en == $past(pwdata[0]) && drive_sel == $past(pwdata[2:1])
            && side_sel == $past(pwdata[3]) && drive_id == $past(pwdata[4]);
    endproperty
    a_porta_write: assert property (p_porta_write) else $error("port a write lost");

    property p_fast_clk;
        @(posedge pclk) disable iff (!presetn)
        // Size held one cycle before the edge, so no divider restart hides in it
        drive_size_large_sel ##1 (tog && drive_size_large_sel) ##1 drive_size_large_sel[*5]
        |-> tog && !$past(tog, 1) && !$past(tog, 4);
    endproperty
    a_fast_clk: assert property (p_fast_clk) else $error("disk clock not 2 MHz");

    property p_slow_clk;
        @(posedge pclk) disable iff (!presetn)
        !drive_size_large_sel ##1 (tog && !drive_size_large_sel)
        ##1 (!drive_size_large_sel)[*8]
        ##1 !drive_size_large_sel ##1 !drive_size_large_sel
        |-> tog && !$past(tog, 1) && !$past(tog, 5) && !$past(tog, 9);
    endproperty
    a_slow_clk: assert property (p_slow_clk) else $error("disk clock not 1 MHz");

    property p_separator;
        @(posedge pclk) disable iff (!presetn)
        1'b1 |=> ext_sep_sel == $past(drive_size_large_sel);
    endproperty
    a_separator: assert property (p_separator) else $error("separator wrong");

    property p_key_take;
        @(posedge pclk) disable iff (!presetn)
        kbd_strobe && !strobe_q_r |=> kbd_r == $past(kbd_data) && kbd_ready_r;
    endproperty
    a_key_take: assert property (p_key_take) else $error("key byte not taken");

endmodule

`default_nettype wire

// file: rtl/bmg_pkg.sv
package bmg_pkg;

    // ****************************************
    // Register map (byte addresses)
    // ****************************************
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] PORTA_ADDR = 8'h00;
    localparam logic [ADDR_W-1:0] PORTB_ADDR = 8'h04;
    localparam logic [ADDR_W-1:0] STATUS_ADDR = 8'h08;

    // Port A fields: {drive_id, side, drive_sel[1:0], bank_en}
    typedef struct packed {
        logic drive_id;
        logic side;
        logic [1:0] drive_sel;
        logic bank_en;
    } bmg_porta_t;

    localparam bmg_porta_t PORTA_RST = '{drive_id: 1'b0, side: 1'b0,
                                         drive_sel: 2'h0, bank_en: 1'b1};
    localparam int PORTA_W = 5;

    // Status bit positions
    localparam int ST_KBD_READY = 0;
    localparam int ST_SIZE_LARGE = 1;
    localparam int ST_BANK_EN = 2;

    // ****************************************
    // Memory map, upper address nibble and top two bits
    // ****************************************
    localparam logic [3:0] ROM_PAGE = 4'h0;
    localparam logic [3:0] CRT_PAGE = 4'h3;
    localparam logic [1:0] LOW16K_TOP = 2'h0;

    typedef struct packed {
        logic rom_sel;
        logic crt_sel;
        logic ram_sel;
    } bmg_mem_sel_t;

    // ****************************************
    // Disk controller clock
    // ****************************************
    localparam int SYS_CLK_HZ = 20_000_000;
    localparam int FDC_FAST_HZ = 2_000_000;
    localparam int FDC_SLOW_HZ = 1_000_000;
    localparam int FAST_HALF = SYS_CLK_HZ / (2 * FDC_FAST_HZ);
    localparam int SLOW_HALF = SYS_CLK_HZ / (2 * FDC_SLOW_HZ);
    localparam int DIV_W = 4;

endpackage

// file: verification/bank_map_disk_clock_glue_bench.sv
`timescale 1ns/1ns
`default_nettype none
module bank_map_disk_clock_glue_bench;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, e;
    logic [bmg_pkg::ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [15:0] cpu_addr;
    bmg_pkg::bmg_mem_sel_t mem_sel;
    logic bank_en, side_sel, drive_id, fdc_clk, ext_sep_sel;
    logic [1:0] drive_sel;
    logic drive_size_large_sel = 1'b0;
    logic [7:0] kbd_data = 8'h00;
    logic kbd_strobe = 1'b0;
    int err_total = 0;
    int n_checks = 0;
    logic [15:0] adr [8] = '{16'h0000, 16'h0fff, 16'h1000, 16'h2fff,
                             16'h3000, 16'h3fff, 16'h4000, 16'hf000};
    logic [2:0] on_sel [8] = '{3'h4, 3'h4, 3'h0, 3'h0, 3'h2, 3'h2, 3'h1, 3'h1};
    always #25 pclk = ~pclk;
    bmg_glue dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .cpu_addr, .mem_sel, .bank_en, .drive_sel,
        .side_sel, .drive_id, .drive_size_large_sel, .fdc_clk, .ext_sep_sel,
        .kbd_data, .kbd_strobe);
    bmg_cpu_model cpu_u (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .cpu_addr);
    // ********************
    // Helpers
    // ********************
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        cpu_u.xfer(1'b1, a, d, q, e);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic err);
        cpu_u.xfer(1'b0, a, 32'h0, q, e);
        chk("prdata", exp, q);
        chk("pslverr", 32'(err), 32'(e));
    endtask
    task automatic decode(input logic on);
        for (int i = 0; i < 8; i++) begin
            @(posedge pclk);
            cpu_u.fetch(adr[i]);
            @(negedge pclk);
            chk("mem_sel", on ? 32'(on_sel[i]) : 32'h1, 32'(mem_sel));
        end
        @(posedge pclk);
    endtask
    // Measures one full half period after the divider settles
    task automatic half(input logic big, input int n_exp);
        int n;
        logic v;
        drive_size_large_sel <= big;
        repeat (30) @(posedge pclk);
        @(negedge pclk);
        chk("ext_sep_sel", 32'(big), 32'(ext_sep_sel));
        v = fdc_clk;
        while (fdc_clk === v) @(negedge pclk);
        v = fdc_clk;
        n = 0;
        while (fdc_clk === v) begin
            @(negedge pclk);
            n++;
        end
        chk("fdc_clk half period", n_exp, n);
        @(posedge pclk);
    endtask
    task automatic give_verdict();
        $display("Checks %0d, mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // ********************
    // Tests
    // ********************
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        chk("bank_en", 32'h1, 32'(bank_en));
        @(posedge pclk);
        rd(bmg_pkg::PORTA_ADDR, 32'h01, 1'b0);
        decode(1'b1);
        wr(bmg_pkg::PORTA_ADDR, 32'h1e);
        @(negedge pclk);
        chk("port a", 32'h1e, {27'h0, drive_id, side_sel, drive_sel, bank_en});
        decode(1'b0);
        wr(bmg_pkg::PORTA_ADDR, 32'h01);
        decode(1'b1);
        wr(8'h0c, 32'h00);
        rd(8'h0c, 32'h0, 1'b1);
        rd(bmg_pkg::PORTA_ADDR, 32'h01, 1'b0);
        kbd_data <= 8'ha5;
        kbd_strobe <= 1'b1;
        @(posedge pclk);
        kbd_strobe <= 1'b0;
        kbd_data <= 8'h5a;
        @(posedge pclk);
        rd(bmg_pkg::STATUS_ADDR, 32'h5, 1'b0);
        rd(bmg_pkg::PORTB_ADDR, 32'ha5, 1'b0);
        rd(bmg_pkg::STATUS_ADDR, 32'h4, 1'b0);
        // A held strobe must load its byte only once
        kbd_data <= 8'h3c;
        kbd_strobe <= 1'b1;
        @(posedge pclk);
        kbd_data <= 8'hc3;
        @(posedge pclk);
        kbd_strobe <= 1'b0;
        rd(bmg_pkg::PORTB_ADDR, 32'h3c, 1'b0);
        half(1'b1, 5);
        rd(bmg_pkg::STATUS_ADDR, 32'h6, 1'b0);
        half(1'b0, 10);
        wr(bmg_pkg::PORTA_ADDR, 32'h00);
        @(negedge pclk);
        chk("bank_en before reset", 32'h0, 32'(bank_en));
        @(posedge pclk);
        presetn <= 1'b0;
        @(negedge pclk);
        chk("bank_en in reset", 32'h1, 32'(bank_en));
        @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(bmg_pkg::PORTA_ADDR, 32'h01, 1'b0);
        give_verdict();
    end
    // Whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge pclk);
        err_total++;
        give_verdict();
    end
endmodule
`default_nettype wire

// file: verification/bmg_cpu_model.sv
`timescale 1ns/1ns
`default_nettype none
module bmg_cpu_model (
    input wire logic pclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [bmg_pkg::ADDR_W-1:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    output logic [15:0] cpu_addr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        cpu_addr = 16'hf000;
    end
    // Port A writes steer bank, drives, id and side
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        // One idle edge first, so a release and a new setup never share a time step
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Stale data must not look valid
        pwdata <= ~d;
    endtask
    task automatic fetch(input logic [15:0] a);
        cpu_addr <= a;
    endtask
endmodule
`default_nettype wire
